// ===== rtl/bsr_buck_two_setpoint_regs.sv
`timescale 1ns/1ps
`include "bsr_defines.svh"


module bsr_buck_two_setpoint_regs
  import bsr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire bsr_req_s    req,
  input  wire logic        cfg_load,
  input  wire logic        cfg_range,
  input  wire bsr_state_e  op_state,
  output bsr_ctrl_s        ctrl,
  output bsr_target_s      target,
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  output logic             rd_hit
);

  // ****************************************************************
  // Address decode
  // ****************************************************************

  localparam int NUM_SP = 3;

  logic [NUM_SP-1:0] sp_sel;
  logic              mode_sel;
  logic              config_sel;
  logic              any_sel;
  logic [NUM_SP-1:0] sp_wr;
  logic              mode_wr;
  logic              config_wr;

  // Set-point registers sit at consecutive addresses, one per state
  // normal decode
  assign sp_sel[0]  = (req.addr == `BSR_ADDR_NORMAL);
  assign sp_sel[1]  = (req.addr == `BSR_ADDR_STANDBY);
  assign sp_sel[2]  = (req.addr == `BSR_ADDR_SLEEP);
  assign mode_sel   = (req.addr == `BSR_ADDR_MODE);
  assign config_sel = (req.addr == `BSR_ADDR_CONFIG);
  assign any_sel    = (|sp_sel) | mode_sel | config_sel;

  // Write strobes; unmapped addresses simply change nothing
  // bus-only control
  assign sp_wr      = sp_sel & {NUM_SP{req.wr}};
  assign mode_wr    = mode_sel & req.wr;
  assign config_wr  = config_sel & req.wr;

  // ****************************************************************
  // Write data fields
  // ****************************************************************

  logic [5:0] wr_sp_code;
  logic [3:0] wr_mode_code;
  logic       wr_sleep_bit;
  logic       wr_limit_bit;
  logic [1:0] wr_freq;
  logic [1:0] wr_phase;
  logic [1:0] wr_speed;

  // Fields are sliced once here; bits with no storage are never read,
  // so writes to them are dropped without any masking logic
  // unused bits dropped
  assign wr_sp_code   = req.wdata[`BSR_SP_CODE_HI:`BSR_SP_CODE_LO];
  assign wr_mode_code = req.wdata[`BSR_MODE_CODE_HI:`BSR_MODE_CODE_LO];
  assign wr_sleep_bit = req.wdata[`BSR_MODE_SLEEP];
  assign wr_limit_bit = req.wdata[`BSR_CFG_ILIM];
  assign wr_freq      = req.wdata[`BSR_CFG_FREQ_HI:`BSR_CFG_FREQ_LO];
  assign wr_phase     = req.wdata[`BSR_CFG_PHASE_HI:`BSR_CFG_PHASE_LO];
  assign wr_speed     = req.wdata[`BSR_CFG_SPEED_HI:`BSR_CFG_SPEED_LO];

  // ****************************************************************
  // Shared range bit
  // ****************************************************************

  logic range_bit;

  // Range changes only on a configuration load, never on a bus write,
  // so every state shares one range and the target cannot jump ranges
  // load-only range
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      range_bit <= `BSR_RST_RANGE;
    end else if (cfg_load) begin
      range_bit <= cfg_range;
    end
  end

  // ****************************************************************
  // Set-point registers
  // ****************************************************************

  logic [5:0] sp_code [NUM_SP];
  logic [7:0] sp_read [NUM_SP];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SP; gi++) begin : g_sp
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          sp_code[gi] <= `BSR_RST_SP_CODE;
        end else if (sp_wr[gi]) begin
          sp_code[gi] <= wr_sp_code;
        end
      end

      // Bit 6 mirrors the shared range, bit 7 reads zero
      // each set point mirrors range
      assign sp_read[gi] = {1'b0, range_bit, sp_code[gi]};
    end
  endgenerate

  // ****************************************************************
  // Mode register
  // ****************************************************************

  logic [3:0] mode_code;
  logic       sleep_behaviour_bit;
  logic [7:0] mode_read;

  // Bit 4 and bits 7:6 have no storage at all
  // mode code field
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_code <= `BSR_RST_MODE_CODE;
    end else if (mode_wr) begin
      mode_code <= wr_mode_code;
    end
  end

  // Only acted on while the sequencer sits in sleep
  // sleep behaviour bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sleep_behaviour_bit <= `BSR_RST_SLEEP_BIT;
    end else if (mode_wr) begin
      sleep_behaviour_bit <= wr_sleep_bit;
    end
  end

  assign mode_read = {2'b00, sleep_behaviour_bit, 1'b0, mode_code};

  // ****************************************************************
  // Configuration register
  // ****************************************************************

  logic       current_limit_select;
  logic [1:0] switching_frequency_select;
  logic [1:0] phase_clock_select;
  logic [1:0] voltage_change_speed;
  logic [7:0] config_read;

  // Bit 1 is unused and kept out of storage
  // current limit bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      current_limit_select <= `BSR_RST_BIT;
    end else if (config_wr) begin
      current_limit_select <= wr_limit_bit;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      switching_frequency_select <= `BSR_RST_FIELD2;
    end else if (config_wr) begin
      switching_frequency_select <= wr_freq;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_clock_select <= `BSR_RST_FIELD2;
    end else if (config_wr) begin
      phase_clock_select <= wr_phase;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      voltage_change_speed <= `BSR_RST_FIELD2;
    end else if (config_wr) begin
      voltage_change_speed <= wr_speed;
    end
  end

  assign config_read = {voltage_change_speed, phase_clock_select,
                        switching_frequency_select, 1'b0,
                        current_limit_select};

  // ****************************************************************
  // Read path
  // ****************************************************************

  logic [7:0] next_rd_data;

  // Unmapped addresses answer zero with rd_hit low
  assign next_rd_data = sp_sel[0]  ? sp_read[0]  :
                        sp_sel[1]  ? sp_read[1]  :
                        sp_sel[2]  ? sp_read[2]  :
                        mode_sel   ? mode_read   :
                        config_sel ? config_read : `BSR_RD_IDLE;

  // Read data holds until the next read so a slow transport can
  // shift it out bit by bit without a second capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data  <= `BSR_RD_IDLE;
      rd_valid <= 1'b0;
      rd_hit   <= 1'b0;
    end else begin
      rd_valid <= req.rd;
      if (req.rd) begin
        rd_data <= next_rd_data;
        rd_hit  <= any_sel;
      end
    end
  end

  // ****************************************************************
  // Target selection
  // ****************************************************************

  logic [5:0]           sel_code;
  logic [`BSR_MV_W-1:0] sel_mv;
  logic                 sel_reserved;
  logic                 in_sleep;
  logic                 next_update;
  bsr_target_s          next_target;

  // Unknown state codes fall back to the normal set point
  // state selects set point
  assign sel_code = (op_state == bsr_st_standby) ? sp_code[1] :
                    (op_state == bsr_st_sleep)   ? sp_code[2] :
                    sp_code[0];
  assign in_sleep = (op_state == bsr_st_sleep);

  bsr_voltage_map u_map (
    .range      (range_bit),
    .code       (sel_code),
    .millivolts (sel_mv),
    .reserved   (sel_reserved)
  );

  // Pulse when the applied code or range moves, so the ramp logic can
  // start a voltage change at the programmed speed
  assign next_update = (sel_code != target.code) ||
                       (range_bit != target.range);

  assign next_target = '{
    range:      range_bit,
    code:       sel_code,
    millivolts: sel_mv,
    reserved:   sel_reserved,
    update:     next_update
  };

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      target <= '0;
    end else begin
      target <= next_target;
    end
  end

  // ****************************************************************
  // Regulator controls
  // ****************************************************************

  localparam bsr_ctrl_s CTRL_RST = '{
    mode_code:                  `BSR_RST_MODE_CODE,
    sleep_behaviour_bit:        `BSR_RST_SLEEP_BIT,
    regulator_on:               1'b1,
    pfm_forced:                 1'b0,
    current_limit_select:       `BSR_RST_BIT,
    switching_frequency_select: `BSR_RST_FIELD2,
    phase_clock_select:         `BSR_RST_FIELD2,
    voltage_change_speed:       `BSR_RST_FIELD2
  };

  bsr_ctrl_s next_ctrl;
  logic      next_regulator_on;
  logic      next_pfm_forced;

  // In sleep the behaviour bit turns the stage off or forces
  // pulse-frequency mode; outside sleep the mode code governs alone
  // sleep off or pulse-frequency
  assign next_regulator_on = !(in_sleep && !sleep_behaviour_bit);
  assign next_pfm_forced   = in_sleep && sleep_behaviour_bit;

  // The rest are plain copies, re-timed so every port is a flop output
  assign next_ctrl = '{
    mode_code:                  mode_code,
    sleep_behaviour_bit:        sleep_behaviour_bit,
    regulator_on:               next_regulator_on,
    pfm_forced:                 next_pfm_forced,
    current_limit_select:       current_limit_select,
    switching_frequency_select: switching_frequency_select,
    phase_clock_select:         phase_clock_select,
    voltage_change_speed:       voltage_change_speed
  };

  // Stage stays enabled through reset; mode code takes its reset value
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RST;
    end else begin
      ctrl <= next_ctrl;
    end
  end

endmodule

// ===== rtl/bsr_voltage_map.sv
`timescale 1ns/1ps
`include "bsr_defines.svh"

module bsr_voltage_map
  import bsr_pkg::*;
(
  input  wire logic                 range,
  input  wire logic [5:0]           code,
  output wire logic [`BSR_MV_W-1:0] millivolts,
  output wire logic                 reserved
);

  logic [`BSR_MV_W-1:0] code_wide;
  logic [`BSR_MV_W-1:0] low_mv;
  logic [`BSR_MV_W-1:0] high_mv;

  // Both ranges are linear; high range tops out at 3950 mV, fits 12 bits
  assign code_wide = {6'h00, code};
  assign low_mv    = `BSR_LOW_BASE_MV + `BSR_LOW_STEP_MV * code_wide;
  assign high_mv   = `BSR_HIGH_BASE_MV + `BSR_HIGH_STEP_MV * code_wide;

  assign millivolts = range ? high_mv : low_mv;

  assign reserved = range && (code > `BSR_HIGH_MAX_CODE);

endmodule

// ===== shared/bsr_defines.svh
`ifndef BSR_DEFINES_SVH
`define BSR_DEFINES_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define BSR_ADDR_NORMAL   8'h35
`define BSR_ADDR_STANDBY  8'h36
`define BSR_ADDR_SLEEP    8'h37
`define BSR_ADDR_MODE     8'h38
`define BSR_ADDR_CONFIG   8'h39

// ****************************************************************
// Field positions
// ****************************************************************
`define BSR_SP_CODE_HI    5
`define BSR_SP_CODE_LO    0
`define BSR_SP_RANGE      6
`define BSR_MODE_CODE_HI  3
`define BSR_MODE_CODE_LO  0
`define BSR_MODE_SLEEP    5
`define BSR_CFG_ILIM      0
`define BSR_CFG_FREQ_HI   3
`define BSR_CFG_FREQ_LO   2
`define BSR_CFG_PHASE_HI  5
`define BSR_CFG_PHASE_LO  4
`define BSR_CFG_SPEED_HI  7
`define BSR_CFG_SPEED_LO  6

// ****************************************************************
// Reset values
// ****************************************************************
`define BSR_RST_SP_CODE   6'h00
`define BSR_RST_RANGE     1'h0
`define BSR_RST_MODE_CODE 4'h8
`define BSR_RST_SLEEP_BIT 1'h0
`define BSR_RST_FIELD2    2'h0
`define BSR_RST_BIT       1'h0
`define BSR_RD_IDLE       8'h00

// ****************************************************************
// Set-point to voltage mapping, millivolts
// ****************************************************************
`define BSR_MV_W          12
`define BSR_LOW_BASE_MV   12'h190
`define BSR_LOW_STEP_MV   12'h019
`define BSR_HIGH_BASE_MV  12'h320
`define BSR_HIGH_STEP_MV  12'h032
`define BSR_HIGH_MAX_CODE 6'h32

`endif

// ===== shared/bsr_pkg.sv
`include "bsr_defines.svh"

package bsr_pkg;

  // Operating state of the device power sequencer
  typedef enum logic [1:0] {
    bsr_st_normal,
    bsr_st_standby,
    bsr_st_sleep
  } bsr_state_e;

  // One register access from the serial bus transport
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bsr_req_s;

  // Voltage target handed to the regulator loop
  typedef struct packed {
    logic                 range;
    logic [5:0]           code;
    logic [`BSR_MV_W-1:0] millivolts;
    logic                 reserved;
    logic                 update;
  } bsr_target_s;

  // Static controls of the regulator channel
  typedef struct packed {
    logic [3:0] mode_code;
    logic       sleep_behaviour_bit;
    logic       regulator_on;
    logic       pfm_forced;
    logic       current_limit_select;
    logic [1:0] switching_frequency_select;
    logic [1:0] phase_clock_select;
    logic [1:0] voltage_change_speed;
  } bsr_ctrl_s;

endpackage

// ===== testbench/bsr_host_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Register host on the far side of the bus port
// ****************************************************************
module bsr_host_model
  import bsr_pkg::*;
(
  input  wire logic       clock,
  output bsr_req_s        req,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  input  wire logic       rd_hit
);
  // Idle bus from time zero
  initial req = '0;

  // bus-only setup
  // Address is inverted on release so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    #1 req.wr = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask

  // bus-only readback
  // Answer is taken one cycle after the strobe edge, as the port promises
  task automatic rd(input logic [7:0] a, output logic [9:0] r);
    @(posedge clock);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    #1 req.rd = 1'b0;
    req.addr = ~a;
    r = {rd_valid, rd_hit, rd_data};
  endtask
endmodule

// ===== testbench/bsr_regs_asserts.sv
`timescale 1ns/1ps

// ****************************************************************
// Port checker
// ****************************************************************
module bsr_regs_asserts
  import bsr_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire bsr_req_s    req,
  input wire logic        cfg_load,
  input wire logic        cfg_range,
  input wire bsr_state_e  op_state,
  input wire bsr_ctrl_s   ctrl,
  input wire bsr_target_s target,
  input wire logic [7:0]  rd_data,
  input wire logic        rd_valid,
  input wire logic        rd_hit
);
  logic range_seen;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Shadow of the loaded range; nothing on the bus may move it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      range_seen <= 1'b0;
    end else if (cfg_load) begin
      range_seen <= cfg_range;
    end
  end

  sequence s_rd_sp;
    req.rd && req.addr inside {[8'h35:8'h37]};
  endsequence

  sequence s_rd_map;
    req.rd && req.addr inside {[8'h35:8'h39]};
  endsequence

  AST_RD_PULSE: assert property (
    req.rd |=> rd_valid) else $error("read gave no valid pulse");
  AST_RD_QUIET: assert property (
    !req.rd |=> !rd_valid) else $error("valid pulse without read");
  AST_HIT: assert property (
    s_rd_map |=> rd_hit) else $error("mapped read not flagged");
  AST_MISS: assert property (
    req.rd && !(req.addr inside {[8'h35:8'h39]}) |=>
      rd_data == 8'h00 && !rd_hit) else $error("unmapped read not zero");
  AST_SP_RANGE: assert property (
    s_rd_sp |=> rd_data[7:6] == {1'b0, $past(range_seen)})
    else $error("set point range bit wrong");
  AST_MODE_GAPS: assert property (
    req.rd && req.addr == 8'h38 |=> rd_data[7:6] == 2'h0 && !rd_data[4])
    else $error("mode unused bits set");
  AST_CFG_GAP: assert property (
    req.rd && req.addr == 8'h39 |=> !rd_data[1])
    else $error("config unused bit set");
  AST_MV_LOW: assert property (
    !$past(rst) && !target.range |->
      target.millivolts == 12'h190 + 12'h019 * target.code)
    else $error("low range voltage wrong");
  AST_MV_HIGH: assert property (
    !$past(rst) && target.range |->
      target.millivolts == 12'h320 + 12'h032 * target.code)
    else $error("high range voltage wrong");
  AST_SLEEP_CTRL: assert property (
    1'b1 |=> ctrl.pfm_forced == ($past(op_state) == bsr_st_sleep &&
      ctrl.sleep_behaviour_bit) && ctrl.regulator_on ==
      !($past(op_state) == bsr_st_sleep && !ctrl.sleep_behaviour_bit))
    else $error("sleep behaviour wrong");
  AST_UPDATE: assert property (
    !$past(rst) |-> target.update == (target.code != $past(target.code) ||
      target.range != $past(target.range)))
    else $error("target update pulse wrong");
endmodule

bind bsr_buck_two_setpoint_regs bsr_regs_asserts u_bsr_regs_asserts (
  .clock(clock), .rst(rst), .req(req), .cfg_load(cfg_load),
  .cfg_range(cfg_range), .op_state(op_state), .ctrl(ctrl),
  .target(target), .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit)
);

// ===== testbench/tb_bsr_buck_two_setpoint_regs.sv
`timescale 1ns/1ps

module tb_bsr_buck_two_setpoint_regs
  import bsr_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_load = 1'b0;
  logic        cfg_range = 1'b0;
  bsr_state_e  op_state = bsr_st_normal;
  bsr_req_s    req;
  bsr_ctrl_s   ctrl;
  bsr_target_s target;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        rd_hit;
  logic [5:0]  sp [3];
  logic [7:0]  md;
  logic [7:0]  cf;
  logic        rg;
  logic [7:0]  wa;
  logic [7:0]  wd;
  logic [31:0] x = 32'h00010e22; // Fixed seed, 69154
  int          n_mismatch = 0;
  int          compares = 0;

  always #5 clock = ~clock;

  bsr_buck_two_setpoint_regs u_bsr_buck_two_setpoint_regs (
    .clock(clock), .rst(rst), .req(req), .cfg_load(cfg_load),
    .cfg_range(cfg_range), .op_state(op_state), .ctrl(ctrl),
    .target(target), .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit)
  );

  bsr_host_model u_bsr_host_model (
    .clock(clock), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_hit(rd_hit)
  );

  // ****************************************************************
  // Expectation model
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic hit(input logic [7:0] a);
    return a inside {[8'h35:8'h39]};
  endfunction

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == 8'h38) return md;
    if (a == 8'h39) return cf;
    return hit(a) ? {1'b0, rg, sp[a[1:0] - 2'h1]} : 8'h00;
  endfunction

  // Undefined state codes fall back to the normal set point
  function automatic logic [33:0] exp_st();
    logic [5:0]  c;
    logic        sl;
    logic [11:0] mv;
    c = (op_state == bsr_st_standby) ? sp[1] :
        (op_state == bsr_st_sleep) ? sp[2] : sp[0];
    sl = (op_state == bsr_st_sleep);
    mv = rg ? 12'h320 + 12'h032 * c : 12'h190 + 12'h019 * c;
    return {rg, c, mv, rg && c > 6'h32, md[3:0], md[5], !(sl && !md[5]),
            sl && md[5], cf[0], cf[3:2], cf[5:4], cf[7:6]};
  endfunction

  // Range bits and unused bits never take bus data
  task automatic mdl_wr(input logic [7:0] a, input logic [7:0] d);
    if (a inside {[8'h35:8'h37]}) sp[a[1:0] - 2'h1] = d[5:0];
    if (a == 8'h38) md = {2'h0, d[5], 1'b0, d[3:0]};
    if (a == 8'h39) cf = {d[7:2], 1'b0, d[0]};
  endtask

  task automatic chk_rd(input logic [9:0] g, input logic [9:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH read t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_st(input logic [33:0] g, input logic [33:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH state t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rdchk(input logic [7:0] a);
    logic [9:0] r;
    u_bsr_host_model.rd(a, r);
    chk_rd(r, {1'b1, hit(a), exp_rd(a)});
  endtask

  task automatic check_all();
    for (int a = 8'h33; a <= 8'h3a; a++) rdchk(8'(a));
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (16) @(posedge clock);
    #1 rst = 1'b0;
    sp = '{default: 6'h00};
    md = 8'h08;
    cf = 8'h00;
    rg = 1'b0;
  endtask

  // Stale range value is inverted once the load strobe drops
  task automatic load_range(input logic v);
    @(posedge clock);
    #1 cfg_load = 1'b1;
    cfg_range = v;
    @(posedge clock);
    #1 cfg_load = 1'b0;
    cfg_range = !v;
    rg = v;
  endtask

  task automatic end_of_test();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    do_reset();
    check_all();
    for (int i = 0; i < 60; i++) begin
      x = lfsr(x);
      if (i == 20 || i == 40) begin
        load_range(!rg);
        check_all();
      end
      op_state = bsr_state_e'(x[1:0]);
      wa = 8'h33 + {5'h0, x[4:2]};
      wd = x[15:8];
      if (rg && wa inside {[8'h35:8'h37]} &&
          (wd[5:0] < 6'h18 || wd[5:0] > 6'h32)) begin
        wd[5:0] = 6'h18 + {2'h0, wd[3:0]};
      end
      u_bsr_host_model.wr(wa, wd);
      mdl_wr(wa, wd);
      rdchk(8'h33 + {5'h0, x[20:18]});
      chk_st({target.range, target.code, target.millivolts,
              target.reserved, ctrl}, exp_st());
    end
    do_reset();
    check_all();
    end_of_test();
  end

  // Hang guard, far above the run length
  initial begin
    #50000;
    n_mismatch++;
    end_of_test();
  end
endmodule
